// [core/pmm_pkg.sv]
// Behaviour
// - top half from 800000h is configuration space
// - user access above implemented top raises error
// - fetch address is a 23-bit program counter
// - table access and 32-Kbyte data window supported
// - vector area ends at 0FEh or 1FEh
// - interrupt vector zero sits at 000014h
// - alternate table needs two boot pages, disable bit clear
// - alternate table starts at last boot page
// - alternate table mirrors primary size and order
// - first three alternate slots are reserved
// - vector area counts as boot or general
// - boot segment follows vector area, rest general except the config row
// - final flash row holds configuration words
// - configuration words copied to hidden registers at reset
// - boot sequence word is next-to-last config word
// - fetch addresses word aligned, execution steps by two
package pmm_pkg;
   typedef logic [23:0] paddr_t;

   // address map
   localparam paddr_t CFG_SPACE_BASE = 24'h800000;
   localparam paddr_t VEC_END_SMALL = 24'h0000FE;
   localparam paddr_t VEC_END_LARGE = 24'h0001FE;
   localparam paddr_t INT0_OFS = 24'h000014;
   localparam paddr_t ALT_RSVD_END = 24'h000004;
   localparam paddr_t WORD_STEP = 24'h000002;
   localparam int PC_BITS = 23;
   localparam int WIN_BITS = 15;
   localparam int PAGE_BITS = 8;

   // security word layout in the hidden configuration copy
   localparam int CFGW_SEC = 0;
   localparam int SEC_PAGES_LSB = 0;
   localparam int SEC_PAGES_W = 8;
   localparam int SEC_ALT_DIS_BIT = 8;
   localparam int SEC_VEC_BOOT_BIT = 9;
   localparam logic [7:0] MIN_ALT_PAGES = 8'h02;

   // register offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
   localparam logic [7:0] REG_ERR_ADDR = 8'h10;
   localparam int IRQ_W = 2;
   localparam int IRQ_ADDR_ERR = 0;
   localparam int IRQ_CFG_DONE = 1;
   localparam int ST_READY_BIT = 0;
   localparam int ST_ALT_BIT = 1;
   localparam int ST_VBOOT_BIT = 2;
   localparam int ST_PAGES_LSB = 8;

   // access ports
   localparam int PORT_PC = 0;
   localparam int PORT_TBL = 1;
   localparam int PORT_WIN = 2;
   localparam int NPORTS = 3;

   typedef struct packed {
      logic valid;
      logic write;
      paddr_t addr;
   } acc_req_t;

   typedef struct packed {
      logic valid;
      logic write;
      paddr_t addr;
      logic cfg_space;
      logic unimpl;
      logic vec_area;
      logic boot;
      logic general;
      logic cfg_row;
      logic alt_vec;
   } dec_res_t;

   typedef struct packed {
      logic alt_en;
      logic vec_in_boot;
      paddr_t boot_end;
      paddr_t last_boot_page_base;
   } seg_cfg_t;

   typedef enum logic [1:0] {
      LD_ISSUE = 2'b00,
      LD_WAIT = 2'b01,
      LD_CAPT = 2'b10,
      LD_DONE = 2'b11
   } load_st_t;
endpackage

// [core/pmm_region_decode.sv]
`timescale 1ns/10ps
module pmm_region_decode
   import pmm_pkg::*;
#(
   parameter paddr_t PROG_TOP = 24'h02AFFE,
   parameter paddr_t VEC_END = 24'h0001FE,
   parameter paddr_t CFG_ROW_BASE = 24'h02AF00
)
(
   // access and segment setup
   input acc_req_t req,
   input seg_cfg_t seg,
   // classification
   output dec_res_t res
);
   logic user;
   logic impl;

   // split the map and classify one address
   always_comb
   begin
      user = (req.addr < CFG_SPACE_BASE);
      impl = user && (req.addr <= PROG_TOP);
      res = '0;
      res.valid = req.valid;
      res.write = req.write;
      res.addr = req.addr;
      res.cfg_space = !user;
      res.unimpl = user && !impl;
      res.vec_area = impl && (req.addr <= VEC_END);
      res.cfg_row = impl && (req.addr >= CFG_ROW_BASE);
      // vector area joins boot or general by security setting
      if (res.vec_area)
      begin
         res.boot = seg.vec_in_boot;
         res.general = !seg.vec_in_boot;
      end
      else if (impl && !res.cfg_row)
      begin
         res.boot = (req.addr < seg.boot_end);
         res.general = !res.boot;
      end
      res.alt_vec = seg.alt_en && res.boot && (req.addr >= seg.last_boot_page_base)
         && (req.addr <= seg.last_boot_page_base + VEC_END);
   end
endmodule

// [core/pmm_map_decoder.sv]
`timescale 1ns/10ps
module pmm_map_decoder
   import pmm_pkg::*;
#(
   parameter paddr_t PROG_TOP = 24'h02AFFE,
   parameter bit LARGE_IVT = 1'b1,
   parameter int ROW_WORDS = 128,
   parameter int PAGE_WORDS = 1024,
   parameter int CFG_WORDS = 8
)
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic irq,
   // core access requests
   input wire logic pc_valid,
   input wire logic [PC_BITS-1:0] pc_addr,
   input wire logic tbl_valid,
   input wire logic tbl_write,
   input wire paddr_t tbl_addr,
   input wire logic win_valid,
   input wire logic win_write,
   input wire logic [WIN_BITS-1:0] win_offset,
   input wire logic vec_valid,
   input wire logic vec_use_alt,
   input wire logic [7:0] vec_num,
   // decode results
   output dec_res_t [NPORTS-1:0] res,
   output paddr_t pc_next,
   output logic addr_err,
   output paddr_t vec_addr,
   output logic vec_ok,
   output logic vec_alt,
   // configuration flash read port
   output logic cfg_rd_en,
   output paddr_t cfg_rd_addr,
   input wire paddr_t cfg_rd_data,
   output logic cfg_ready,
   output paddr_t boot_seq_word
);
   localparam paddr_t VEC_END = LARGE_IVT ? VEC_END_LARGE : VEC_END_SMALL;
   localparam paddr_t BOOT_START = VEC_END + WORD_STEP;
   localparam paddr_t PAGE_SPAN = paddr_t'(2 * PAGE_WORDS);
   localparam paddr_t CFG_ROW_BASE = paddr_t'(PROG_TOP + 2 - 2 * ROW_WORDS);
   localparam paddr_t CFG_WORD_BASE = paddr_t'(PROG_TOP + 2 - 2 * CFG_WORDS);
   localparam int CW = $clog2(CFG_WORDS);
   localparam logic [CW-1:0] CFG_LAST = CW'(CFG_WORDS - 1);
   localparam int BSEQ_IDX = CFG_WORDS - 2;
   localparam paddr_t SEC_RESET = 24'h000100;

   // hidden configuration copy
   load_st_t ld_st_r, ld_st_nxt;
   logic [CW-1:0] ld_cnt_r, ld_cnt_nxt;
   logic cfg_rd_en_r, cfg_rd_en_nxt;
   paddr_t cfg_rd_addr_r, cfg_rd_addr_nxt;
   paddr_t cfg_mem_r [CFG_WORDS];
   logic cfg_we;
   logic cfg_ready_r, cfg_ready_nxt;
   logic cfg_done_ev;

   // reset-time copy of the configuration words from flash
   always_comb
   begin
      ld_st_nxt = ld_st_r;
      ld_cnt_nxt = ld_cnt_r;
      cfg_rd_en_nxt = 1'b0;
      cfg_rd_addr_nxt = cfg_rd_addr_r;
      cfg_we = 1'b0;
      cfg_ready_nxt = cfg_ready_r;
      cfg_done_ev = 1'b0;
      unique case (ld_st_r)
         LD_ISSUE:
         begin
            cfg_rd_en_nxt = 1'b1;
            cfg_rd_addr_nxt = CFG_WORD_BASE + paddr_t'({ld_cnt_r, 1'b0});
            ld_st_nxt = LD_WAIT;
         end
         LD_WAIT: ld_st_nxt = LD_CAPT;
         LD_CAPT:
         begin
            cfg_we = 1'b1;
            if (ld_cnt_r == CFG_LAST)
            begin
               ld_st_nxt = LD_DONE;
               cfg_ready_nxt = 1'b1;
               cfg_done_ev = 1'b1;
            end
            else
            begin
               ld_cnt_nxt = ld_cnt_r + 1'b1;
               ld_st_nxt = LD_ISSUE;
            end
         end
         LD_DONE: ld_st_nxt = LD_DONE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ld_st_r <= LD_ISSUE;
         ld_cnt_r <= '0;
         cfg_rd_en_r <= 1'b0;
         cfg_rd_addr_r <= '0;
         cfg_ready_r <= 1'b0;
         for (int i = 0; i < CFG_WORDS; i++)
            cfg_mem_r[i] <= SEC_RESET;
      end
      else
      begin
         ld_st_r <= ld_st_nxt;
         ld_cnt_r <= ld_cnt_nxt;
         cfg_rd_en_r <= cfg_rd_en_nxt;
         cfg_rd_addr_r <= cfg_rd_addr_nxt;
         cfg_ready_r <= cfg_ready_nxt;
         if (cfg_we)
            cfg_mem_r[ld_cnt_r] <= cfg_rd_data; // only flash feeds it
      end
   end

   // segment layout from the security word
   seg_cfg_t seg;
   logic [SEC_PAGES_W-1:0] boot_pages;
   always_comb
   begin
      boot_pages = cfg_mem_r[CFGW_SEC][SEC_PAGES_LSB +: SEC_PAGES_W];
      seg.vec_in_boot = cfg_mem_r[CFGW_SEC][SEC_VEC_BOOT_BIT];
      seg.boot_end = paddr_t'(BOOT_START + boot_pages * PAGE_SPAN);
      seg.last_boot_page_base = seg.boot_end - PAGE_SPAN;
      seg.alt_en = (boot_pages >= MIN_ALT_PAGES)
         && !cfg_mem_r[CFGW_SEC][SEC_ALT_DIS_BIT];
   end

   // the three access paths, one decoder each
   acc_req_t [NPORTS-1:0] req;
   dec_res_t [NPORTS-1:0] dec;
   logic [PAGE_BITS-1:0] win_page_r, win_page_nxt;
   always_comb
   begin
      req[PORT_PC] = '{pc_valid, 1'b0,
         {1'b0, pc_addr[PC_BITS-1:1], 1'b0}};
      req[PORT_TBL] = '{tbl_valid, tbl_write, tbl_addr};
      req[PORT_WIN] = '{win_valid, win_write, {1'b0, win_page_r, win_offset}};
   end

   for (genvar g = 0; g < NPORTS; g++)
   begin : g_dec
      pmm_region_decode #(
         .PROG_TOP(PROG_TOP),
         .VEC_END(VEC_END),
         .CFG_ROW_BASE(CFG_ROW_BASE)
      ) u_dec (
         .req(req[g]),
         .seg(seg),
         .res(dec[g])
      );
   end

   // registered results, error pulse and vector placement
   dec_res_t [NPORTS-1:0] res_r, res_nxt;
   paddr_t pc_next_r, pc_next_nxt;
   logic addr_err_r, addr_err_nxt;
   paddr_t err_addr_r, err_addr_nxt;
   paddr_t vec_addr_r, vec_addr_nxt;
   logic vec_ok_r, vec_ok_nxt;
   logic vec_alt_r, vec_alt_nxt;
   paddr_t vec_ofs;
   always_comb
   begin
      res_nxt = dec;
      pc_next_nxt = dec[PORT_PC].addr + WORD_STEP;
      addr_err_nxt = 1'b0;
      err_addr_nxt = err_addr_r;
      for (int p = NPORTS - 1; p >= 0; p--)
         if (dec[p].valid && dec[p].unimpl)
         begin
            addr_err_nxt = 1'b1;
            err_addr_nxt = dec[p].addr;
         end
      vec_ofs = INT0_OFS + paddr_t'({vec_num, 1'b0});
      vec_alt_nxt = vec_valid && vec_use_alt && seg.alt_en;
      vec_addr_nxt = vec_alt_nxt ? seg.last_boot_page_base + vec_ofs : vec_ofs;
      vec_ok_nxt = vec_valid && (vec_ofs <= VEC_END);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         res_r <= '0;
         pc_next_r <= '0;
         addr_err_r <= 1'b0;
         err_addr_r <= '0;
         vec_addr_r <= '0;
         vec_ok_r <= 1'b0;
         vec_alt_r <= 1'b0;
      end
      else
      begin
         res_r <= res_nxt;
         pc_next_r <= pc_next_nxt;
         addr_err_r <= addr_err_nxt;
         err_addr_r <= err_addr_nxt;
         vec_addr_r <= vec_addr_nxt;
         vec_ok_r <= vec_ok_nxt;
         vec_alt_r <= vec_alt_nxt;
      end
   end

   // ahb-lite slave: writes zero wait, reads one wait state
   logic [7:0] bus_addr_r, bus_addr_nxt;
   logic wr_pend_r, wr_pend_nxt;
   logic rd_pend_r, rd_pend_nxt;
   logic hreadyout_r, hreadyout_nxt;
   logic [31:0] hrdata_r, hrdata_nxt;
   logic [IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
   logic [IRQ_W-1:0] irq_mask_r, irq_mask_nxt;
   logic irq_r, irq_nxt;
   logic take;
   logic [IRQ_W-1:0] ev;
   always_comb
   begin
      take = hsel && htrans[1] && hready;
      bus_addr_nxt = take ? haddr[7:0] : bus_addr_r;
      wr_pend_nxt = take && hwrite;
      rd_pend_nxt = take && !hwrite;
      hreadyout_nxt = !(take && !hwrite);
      hrdata_nxt = hrdata_r;
      win_page_nxt = win_page_r;
      irq_mask_nxt = irq_mask_r;
      ev = '0;
      ev[IRQ_ADDR_ERR] = addr_err_nxt;
      ev[IRQ_CFG_DONE] = cfg_done_ev;
      irq_stat_nxt = irq_stat_r;
      if (wr_pend_r)
         unique case (bus_addr_r)
            REG_CTRL: win_page_nxt = hwdata[PAGE_BITS-1:0];
            REG_IRQ_STAT: irq_stat_nxt = irq_stat_r & ~hwdata[IRQ_W-1:0];
            REG_IRQ_MASK: irq_mask_nxt = hwdata[IRQ_W-1:0];
            default: ;
         endcase
      irq_stat_nxt = irq_stat_nxt | ev; // a new event beats the clear
      irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
      if (rd_pend_r)
      begin
         hrdata_nxt = '0;
         unique case (bus_addr_r)
            REG_CTRL: hrdata_nxt[PAGE_BITS-1:0] = win_page_r;
            REG_STATUS:
            begin
               hrdata_nxt[ST_READY_BIT] = cfg_ready_r;
               hrdata_nxt[ST_ALT_BIT] = seg.alt_en;
               hrdata_nxt[ST_VBOOT_BIT] = seg.vec_in_boot;
               hrdata_nxt[ST_PAGES_LSB +: SEC_PAGES_W] = boot_pages;
            end
            REG_IRQ_STAT: hrdata_nxt[IRQ_W-1:0] = irq_stat_r;
            REG_IRQ_MASK: hrdata_nxt[IRQ_W-1:0] = irq_mask_r;
            REG_ERR_ADDR: hrdata_nxt[23:0] = err_addr_r;
            default: ;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         bus_addr_r <= '0;
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         hreadyout_r <= 1'b1;
         hrdata_r <= '0;
         win_page_r <= '0;
         irq_stat_r <= '0;
         irq_mask_r <= '0;
         irq_r <= 1'b0;
      end
      else
      begin
         bus_addr_r <= bus_addr_nxt;
         wr_pend_r <= wr_pend_nxt;
         rd_pend_r <= rd_pend_nxt;
         hreadyout_r <= hreadyout_nxt;
         hrdata_r <= hrdata_nxt;
         win_page_r <= win_page_nxt;
         irq_stat_r <= irq_stat_nxt;
         irq_mask_r <= irq_mask_nxt;
         irq_r <= irq_nxt;
      end
   end

   // outputs straight from flops, hresp tied to zero
   assign hrdata = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp = 1'b0;
   assign irq = irq_r;
   assign res = res_r;
   assign pc_next = pc_next_r;
   assign addr_err = addr_err_r;
   assign vec_addr = vec_addr_r;
   assign vec_ok = vec_ok_r;
   assign vec_alt = vec_alt_r;
   assign cfg_rd_en = cfg_rd_en_r;
   assign cfg_rd_addr = cfg_rd_addr_r;
   assign cfg_ready = cfg_ready_r;
   assign boot_seq_word = cfg_mem_r[BSEQ_IDX];

   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_cfg_split: assert property (tbl_valid
      |=> res_r[PORT_TBL].cfg_space == $past(tbl_addr[23]))
      else $error("config space split wrong");
   a_err_pulse: assert property ((pc_valid
      && {1'b0, pc_addr[PC_BITS-1:1], 1'b0} > PROG_TOP) |=> addr_err_r)
      else $error("missing address error");
   a_err_cause: assert property (addr_err_r |-> $past(
      (pc_valid && {1'b0, pc_addr[PC_BITS-1:1], 1'b0} > PROG_TOP)
      || (tbl_valid && !tbl_addr[23] && tbl_addr > PROG_TOP)
      || (win_valid && {1'b0, win_page_r, win_offset} > PROG_TOP)))
      else $error("address error without cause");
   a_pc_step: assert property (pc_valid |=>
      pc_next_r == res_r[PORT_PC].addr + WORD_STEP
      && res_r[PORT_PC].addr == {1'b0, $past(pc_addr[PC_BITS-1:1]), 1'b0})
      else $error("pc alignment or step wrong");
   a_win_map: assert property (win_valid |=>
      res_r[PORT_WIN].addr[22:0] == {$past(win_page_r), $past(win_offset)})
      else $error("window mapping wrong");
   a_int0_addr: assert property ((vec_valid && !vec_use_alt && vec_num == 8'h00)
      |=> vec_addr_r == INT0_OFS && vec_ok_r)
      else $error("interrupt zero misplaced");
   a_alt_gate: assert property (vec_alt_r |-> $past(seg.alt_en)
      && $past(boot_pages) >= MIN_ALT_PAGES)
      else $error("alternate table used while absent");
   a_alt_base: assert property (vec_alt_r |->
      vec_addr_r == $past(seg.last_boot_page_base) + $past(vec_ofs)
      && vec_addr_r > $past(seg.last_boot_page_base) + ALT_RSVD_END)
      else $error("alternate vector misplaced");
   a_cfg_load: assert property ($rose(cfg_ready_r) |->
      $past(ld_cnt_r) == CFG_LAST ##1 cfg_ready_r [*4])
      else $error("configuration copy incomplete");
   a_rd_wait: assert property ((take && !hwrite) |=> !hreadyout_r ##1 hreadyout_r)
      else $error("read wait state wrong");

   c_addr_err: cover property (addr_err_r);
   c_alt_used: cover property (vec_alt_r && vec_ok_r);
   c_cfg_row: cover property (res_r[PORT_TBL].valid && res_r[PORT_TBL].cfg_row);
   c_irq: cover property ($rose(irq_r));
endmodule

// [dv/pmm_flash_cfg_model.sv]
`timescale 1ns/10ps
module flash_cfg_model
   import pmm_pkg::*;
#(
   parameter paddr_t BASE = 24'h02AFF0,
   parameter int WORDS = 8
)
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // configuration read port
   input wire logic rd_en,
   input wire paddr_t rd_addr,
   output paddr_t rd_data
);
   // configuration words in the last flash row; only programming them changes setup
   paddr_t mem [WORDS];
   paddr_t idx;

   // word index from the first configuration word
   assign idx = (rd_addr - BASE) >> 1;

   // answer in the cycle after the strobe, then invert every cycle so stale data matches the last answer only every second cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         rd_data <= 24'h000000;
      else if (rd_en)
         rd_data <= mem[idx];
      else
         rd_data <= ~rd_data;
   end
endmodule

// [dv/program_memory_map_decoder_test.sv]
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
   $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module program_memory_map_decoder_test;
   import pmm_pkg::*;
   typedef struct packed {logic err; dec_res_t d;} exp_t;
   localparam paddr_t TOP = 24'h02AFFE;
   localparam paddr_t DIR [17] = '{24'h000000, 24'h0000FE, 24'h000100, 24'h0001FE,
      24'h000200, 24'h001200, 24'h001214, 24'h0013FE, 24'h001400, 24'h0019FE, 24'h001A00,
      24'h02AEFE, 24'h02AF00, 24'h02AFFE, 24'h02B000, 24'h800000, 24'hFFFFFE};
   localparam paddr_t SEC [3] = '{24'h000001, 24'h000103, 24'h000203};
   localparam logic [7:0] VN [5] = '{8'h00, 8'h01, 8'h75, 8'hF5, 8'hF6};
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic pc_valid, tbl_valid, tbl_write, win_valid, win_write, vec_valid, vec_use_alt;
   logic [PC_BITS-1:0] pc_addr;
   logic [WIN_BITS-1:0] win_offset;
   logic [7:0] vec_num, pages, page;
   paddr_t tbl_addr, pc_next, vec_addr, cfg_rd_addr, cfg_rd_data, boot_seq_word, be, last_boot_page_base, a;
   logic vec_ok, vec_alt, addr_err, cfg_rd_en, cfg_ready, vboot, alt_en, prev_rdy, vq;
   dec_res_t [NPORTS-1:0] res;
   exp_t acc_q[$];
   logic [25:0] vec_q[$];
   logic [31:0] rd_q[$];
   int n_errors, samples_checked, seed, cycles;

   pmm_map_decoder dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .pc_valid(pc_valid),
      .pc_addr(pc_addr), .tbl_valid(tbl_valid), .tbl_write(tbl_write), .tbl_addr(tbl_addr),
      .win_valid(win_valid), .win_write(win_write), .win_offset(win_offset),
      .vec_valid(vec_valid), .vec_use_alt(vec_use_alt), .vec_num(vec_num), .res(res),
      .pc_next(pc_next), .addr_err(addr_err), .vec_addr(vec_addr), .vec_ok(vec_ok),
      .vec_alt(vec_alt), .cfg_rd_en(cfg_rd_en), .cfg_rd_addr(cfg_rd_addr),
      .cfg_rd_data(cfg_rd_data), .cfg_ready(cfg_ready), .boot_seq_word(boot_seq_word));

   flash_cfg_model flash (.hclk(hclk), .hresetn(hresetn), .rd_en(cfg_rd_en),
      .rd_addr(cfg_rd_addr), .rd_data(cfg_rd_data));

   // 200 MHz clock
   initial
   begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   // expected classification of one decoded address
   function automatic exp_t expect_dec(paddr_t x, logic w);
      exp_t e;
      logic impl, code;
      e = '0;
      e.d.valid = 1'b1;
      e.d.write = w;
      e.d.addr = x;
      e.d.cfg_space = x >= CFG_SPACE_BASE;
      e.d.unimpl = !e.d.cfg_space && x > TOP;
      e.err = e.d.unimpl;
      impl = !e.d.cfg_space && !e.d.unimpl;
      e.d.vec_area = x <= VEC_END_LARGE;
      e.d.cfg_row = impl && x >= 24'h02AF00;
      code = impl && !e.d.vec_area && !e.d.cfg_row;
      e.d.boot = (e.d.vec_area && vboot) || (code && x < be);
      e.d.general = (e.d.vec_area && !vboot) || (code && x >= be);
      e.d.alt_vec = alt_en && code && x >= last_boot_page_base && x <= last_boot_page_base + VEC_END_LARGE;
      return e;
   endfunction

   // one cycle of core requests; port 3 means no access
   task step(input logic [1:0] p, input paddr_t x, input logic w, input logic vv,
             input logic [7:0] n, input logic va);
      paddr_t v;
      pc_valid <= p == 2'd0;
      tbl_valid <= p == 2'd1;
      win_valid <= p == 2'd2;
      pc_addr <= x[PC_BITS-1:0];
      tbl_addr <= x;
      tbl_write <= w;
      win_write <= w;
      win_offset <= x[WIN_BITS-1:0];
      vec_valid <= vv;
      vec_num <= n;
      vec_use_alt <= va;
      if (p == 2'd0)
         acc_q.push_back(expect_dec({1'b0, x[PC_BITS-1:1], 1'b0},
            1'b0));
      else if (p == 2'd2)
         acc_q.push_back(expect_dec({1'b0, page, x[WIN_BITS-1:0]}, w));
      else if (p == 2'd1)
         acc_q.push_back(expect_dec(x, w));
      v = 24'h000014 + {15'h0, n, 1'b0};
      if (vv)
         vec_q.push_back({(va && alt_en) ? last_boot_page_base + v : v, v <= VEC_END_LARGE, va && alt_en});
      @(posedge hclk);
   endtask

   // single ahb-lite transfer; for a read d is the expected data
   task bus(input logic [31:0] ad, input logic wr, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= ad;
      htrans <= 2'b10;
      hwrite <= wr;
      hsize <= 3'b010;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= wr ? d : 32'h00000000;
      if (!wr)
         rd_q.push_back(d);
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
   endtask

   task print_verdict;
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // result watcher: takes the oldest note whenever an answer appears
   always @(posedge hclk)
   begin
      exp_t e;
      logic [31:0] rx;
      logic [25:0] vx;
      prev_rdy <= hreadyout;
      vq <= vec_valid;
      // read data and response stand at the edge that ends the wait state
      if (prev_rdy === 1'b0 && hreadyout === 1'b1)
      begin
         rx = rd_q.pop_front();
         `CHK(hrdata, rx);
         `CHK(hresp, 1'b0);
      end
      for (int p = 0; p < NPORTS; p++)
         if (res[p].valid === 1'b1)
         begin
            e = acc_q.pop_front();
            `CHK(res[p], e.d);
            `CHK(addr_err, e.err);
            if (p == 0)
               `CHK(pc_next, e.d.addr + WORD_STEP);
         end
      if (res[0].valid !== 1'b1 && res[1].valid !== 1'b1 && res[2].valid !== 1'b1)
         `CHK(addr_err, 1'b0);
      if (vq === 1'b1)
      begin
         vx = vec_q.pop_front();
         `CHK({vec_addr, vec_ok, vec_alt}, vx);
      end
   end

   // hang guard
   always @(posedge hclk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         n_errors++;
         print_verdict();
      end
   end

   // three configurations, each loaded by a fresh reset
   initial
   begin
      seed = 12;
      n_errors = 0;
      samples_checked = 0;
      cycles = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h00000000;
      {pc_valid, tbl_valid, tbl_write, win_valid, win_write, vec_valid, vec_use_alt} = 7'h00;
      pc_addr = '0;
      tbl_addr = 24'h000000;
      win_offset = '0;
      vec_num = 8'h00;
      prev_rdy = 1'b1;
      vq = 1'b0;
      for (int i = 0; i < 8; i++)
         flash.mem[i] = 24'h000000;
      flash.mem[6] = 24'h5A0C36;
      for (int ph = 0; ph < 3; ph++)
      begin
         flash.mem[CFGW_SEC] = SEC[ph];
         pages = SEC[ph][7:0];
         vboot = SEC[ph][SEC_VEC_BOOT_BIT];
         alt_en = pages >= MIN_ALT_PAGES && !SEC[ph][SEC_ALT_DIS_BIT];
         be = 24'h000200 + {16'h0000, pages} * 24'h000800;
         last_boot_page_base = be - 24'h000800;
         page = 8'h00;
         hresetn <= 1'b0;
         repeat (5) @(posedge hclk);
         hresetn <= 1'b1;
         while (cfg_ready !== 1'b1) @(posedge hclk);
         `CHK(boot_seq_word, 24'h5A0C36);
         bus(32'(REG_STATUS), 1'b0,
            {16'h0000, pages, 5'h00, vboot, alt_en, 1'b1});
         if (ph == 2)
         begin
            bus(32'(REG_IRQ_STAT), 1'b0, 32'h00000002);
            bus(32'(REG_IRQ_STAT), 1'b1, 32'h00000002);
            bus(32'(REG_IRQ_MASK), 1'b1, 32'h00000001);
            bus(32'(REG_CTRL), 1'b1, 32'h00000005);
            page = 8'h05;
            bus(32'(REG_CTRL), 1'b0, 32'h00000005);
            bus(32'h00000020, 1'b1, 32'h0000FFFF);
            bus(32'h00000020, 1'b0, 32'h00000000);
            step(2'd1, 24'h02B000, 1'b0, 1'b0, 8'h00, 1'b0);
            step(2'd3, 24'h000000, 1'b0, 1'b0, 8'h00, 1'b0);
            repeat (3) @(posedge hclk);
            `CHK(irq, 1'b1);
            bus(32'(REG_ERR_ADDR), 1'b0, 32'h0002B000);
            bus(32'(REG_IRQ_MASK), 1'b1, 32'h00000000);
            repeat (2) @(posedge hclk);
            `CHK(irq, 1'b0);
            bus(32'(REG_IRQ_STAT), 1'b1, 32'h00000001);
            bus(32'(REG_IRQ_STAT), 1'b0, 32'h00000000);
         end
         foreach (DIR[i])
            step((DIR[i] >= CFG_SPACE_BASE) ? 2'd1 : {1'b0, i[0]}, DIR[i],
               1'b0, 1'b0, 8'h00, 1'b0);
         step(2'd0, 24'h000301, 1'b0, 1'b0, 8'h00, 1'b0);
         step(2'd2, 24'h000000, 1'b1, 1'b0, 8'h00, 1'b0);
         step(2'd2, 24'h007FFE, 1'b0, 1'b0, 8'h00, 1'b0);
         foreach (VN[i])
            for (int al = 0; al < 2; al++)
               if (al == 0 || VN[i] != 8'hF6)
                  step(2'd3, 24'h000000, 1'b0, 1'b1, VN[i], al[0]);
         repeat (30)
         begin
            a = 24'($unsigned($random(seed)) % 32'h0002B200) & 24'hFFFFFE;
            step({1'b0, a[1]}, a, a[2], a[3], a[11:4], a[5]);
         end
         step(2'd3, 24'h000000, 1'b0, 1'b0, 8'h00, 1'b0);
         repeat (3) @(posedge hclk);
      end
      // every noted result must have shown up
      `CHK(acc_q.size() + vec_q.size() + rd_q.size(), 0);
      print_verdict();
   end
endmodule
